/* File: design/async_memory_port.v */
// Purpose: Pin side of the asynchronous external memory port
// Assumes: Core request port on clk; pins reach the outside via pads
// Notes:   All pin outputs are registered and lag the sequencer by one
//          cycle; pin inputs pass pin_sync before use
`include "async_memory_port_defines.vh"

module async_memory_port #(
  parameter [7:0] STROBE_CYCLES = `STROBE_CYCLES
) (
  input  wire        clk,
  input  wire        reset_n,
  // Core access requests
  input  wire        req_valid,
  input  wire        req_write,
  input  wire        req_cond,
  input  wire [23:0] req_addr,
  input  wire [15:0] req_wdata,
  output wire        req_ready,
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  // Pin sharing configuration, captured on cfg_load; external_port_boot is used directly, not captured
  input  wire        cfg_load,
  input  wire        cfg_addr_flag_en,
  input  wire        cfg_pwm_en,
  input  wire        cfg_data_flag_en,
  input  wire        cfg_parallel_input_path_en,
  input  wire [7:0]  cfg_flag_mode,
  input  wire        external_port_boot,
  // General flags, PWM and timer sources
  input  wire [15:0] gpio_out,
  input  wire [15:0] gpio_out_en,
  input  wire [3:0]  low_flag_out,
  input  wire [3:0]  pwm_out,
  input  wire        timer_expired_out,
  output reg  [15:0] gpio_in,
  output reg  [3:0]  low_flag_in,
  output reg  [1:0]  irq_req,
  output reg  [19:0] parallel_input_path,
  // Address pins
  input  wire [23:0] addr_in,
  output reg  [23:0] addr_out,
  output reg  [23:0] addr_oe,
  // Data pins
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg  [15:0] data_oe,
  // Low multipurpose flag pins
  input  wire [3:0]  flag_in,
  output reg  [3:0]  flag_out,
  output reg  [3:0]  flag_oe,
  // Memory control pins
  input  wire        ext_access_ack,
  output reg  [1:0]  bank_select_n,
  output reg         ext_read_strobe_n,
  output reg         ext_write_strobe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Bank decode, with boot forcing bank 1
  function [1:0] decode_bank;
    input [23:0] a;
    input        boot;
    begin
      if (boot)
        decode_bank = 2'h1;
      else
        decode_bank = a[`BANK_MSB:`BANK_LSB];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  wire [44:0] sync_bus;
  wire [23:0] addr_s;
  wire [15:0] data_s;
  wire [3:0]  flag_s;
  wire        ack_s;

  pin_sync #(
    .WIDTH (45)
  ) u_pin_sync (
    .clk       (clk),
    .reset_n   (reset_n),
    .async_in  ({ext_access_ack, flag_in, data_in, addr_in}),
    .reset_val (45'h1fffffffffff),
    .sync_out  (sync_bus)
  );

  assign addr_s = sync_bus[23:0];
  assign data_s = sync_bus[39:24];
  assign flag_s = sync_bus[43:40];
  assign ack_s  = sync_bus[44];

  ////////////////////////////////////////////////////////////////////////////
  // Pin sharing configuration
  reg       addr_flag_en;
  reg       pwm_en;
  reg       data_flag_en;
  reg       parallel_input_path_en;
  reg [7:0] flag_mode;

  always @(posedge clk) begin
    if (!reset_n) begin
      addr_flag_en <= `ADDR_FLAG_EN_RESET;
      pwm_en       <= `PWM_EN_RESET;
      data_flag_en <= `DATA_FLAG_EN_RESET;
      parallel_input_path_en      <= `PARALLEL_INPUT_PATH_EN_RESET;
      flag_mode    <= `FMODE_RESET;
    end else if (cfg_load) begin
      addr_flag_en <= cfg_addr_flag_en;
      pwm_en       <= cfg_pwm_en;
      data_flag_en <= cfg_data_flag_en;
      parallel_input_path_en      <= cfg_parallel_input_path_en;
      flag_mode    <= cfg_flag_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_SETUP  = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD   = 3'h3;

  reg [2:0]  state;
  reg [7:0]  cnt;
  reg [23:0] addr_q;
  reg [15:0] wdata_q;
  reg        write_q;
  reg [1:0]  bank_q;

  assign req_ready = (state == ST_IDLE);

  always @(posedge clk) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      cnt       <= 8'h00;
      addr_q    <= 24'h000000;
      wdata_q   <= 16'h0000;
      write_q   <= 1'b0;
      bank_q    <= 2'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_valid) begin
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            write_q <= req_write;
            bank_q  <= decode_bank(req_addr, external_port_boot);
            if (req_cond)
              state <= ST_SETUP;
            else
              rsp_valid <= 1'b1;
          end
        end
        ST_SETUP: begin
          state <= ST_STROBE;
          cnt   <= STROBE_CYCLES - 8'h01;
        end
        ST_STROBE: begin
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else if (ack_s) begin
            state <= ST_HOLD;
            if (!write_q)
              rsp_rdata <= data_s;
          end
        end
        ST_HOLD: begin
          state     <= ST_IDLE;
          rsp_valid <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next pin values
  wire        active = (state != ST_IDLE);
  wire        strobe = (state == ST_STROBE);
  reg  [23:0] next_addr_out;
  reg  [23:0] next_addr_oe;
  reg  [15:0] next_data_out;
  reg  [15:0] next_data_oe;
  reg  [3:0]  next_flag_out;
  reg  [3:0]  next_flag_oe;
  reg  [1:0]  next_bank_select_n;
  reg  [1:0]  fm;
  integer     i;
  integer     j;

  always @* begin
    next_addr_out = addr_q;
    next_addr_oe  = 24'hffffff;
    for (i = 0; i < 24; i = i + 1) begin
      if (parallel_input_path_en && i >= `ADDR_PARALLEL_INPUT_PATH_LSB && i <= `ADDR_PARALLEL_INPUT_PATH_MSB) begin
        next_addr_out[i] = 1'b0;
        next_addr_oe[i]  = 1'b0;
      end else if (addr_flag_en && i >= `ADDR_FLAG_LSB &&
                   i <= `ADDR_FLAG_MSB) begin
        next_addr_out[i] = gpio_out[i];
        next_addr_oe[i]  = gpio_out_en[i];
      end else if (pwm_en && i <= `ADDR_PWM_MSB) begin
        next_addr_out[i] = pwm_out[i - `ADDR_PWM_LSB];
      end
    end
  end

  always @* begin
    next_data_out = wdata_q;
    next_data_oe  = {16{active & write_q}};
    if (data_flag_en) begin
      next_data_out[7:0] = gpio_out[7:0];
      next_data_oe[7:0]  = gpio_out_en[7:0];
    end
  end

  always @* begin
    next_bank_select_n = 2'h3;
    if (active && bank_q == 2'h0)
      next_bank_select_n[0] = 1'b0;
    if (active && bank_q == 2'h1)
      next_bank_select_n[1] = 1'b0;
  end

  always @* begin
    next_flag_out = low_flag_out;
    next_flag_oe  = 4'h0;
    fm            = 2'h0;
    for (j = 0; j < 4; j = j + 1) begin
      fm = flag_mode[2*j +: 2];
      case (fm)
        `FMODE_OUT: begin
          next_flag_oe[j] = 1'b1;
        end
        `FMODE_ALT: begin
          if (j == 3) begin
            next_flag_out[j] = timer_expired_out;
            next_flag_oe[j]  = 1'b1;
          end
        end
        `FMODE_SELECT: begin
          if (j >= 2) begin
            next_flag_out[j] = ~(active && bank_q == j[1:0]);
            next_flag_oe[j]  = 1'b1;
          end
        end
        default: begin
          next_flag_oe[j] = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin output registers
  always @(posedge clk) begin
    if (!reset_n) begin
      addr_out           <= 24'h000000;
      addr_oe            <= 24'hffffff;
      data_out           <= 16'h0000;
      data_oe            <= 16'h0000;
      flag_out           <= 4'h0;
      flag_oe            <= 4'h0;
      bank_select_n      <= 2'h3;
      ext_read_strobe_n  <= 1'b1;
      ext_write_strobe_n <= 1'b1;
    end else begin
      addr_out           <= next_addr_out;
      addr_oe            <= next_addr_oe;
      data_out           <= next_data_out;
      data_oe            <= next_data_oe;
      flag_out           <= next_flag_out;
      flag_oe            <= next_flag_oe;
      bank_select_n      <= next_bank_select_n;
      ext_read_strobe_n  <= ~(strobe & ~write_q);
      ext_write_strobe_n <= ~(strobe & write_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampled pin inputs back to the core
  always @(posedge clk) begin
    if (!reset_n) begin
      gpio_in             <= 16'h0000;
      low_flag_in         <= 4'h0;
      irq_req             <= 2'h0;
      parallel_input_path <= 20'h00000;
    end else begin
      gpio_in             <= {addr_s[15:8], data_s[7:0]};
      low_flag_in         <= flag_s;
      irq_req[0]          <= (flag_mode[1:0] == `FMODE_ALT) & ~flag_s[0];
      irq_req[1]          <= (flag_mode[3:2] == `FMODE_ALT) & ~flag_s[1];
      parallel_input_path <= parallel_input_path_en ? addr_s[23:4] : 20'h00000;
    end
  end

endmodule // async_memory_port

/* File: design/async_memory_port_defines.vh */
// Purpose: Constants for the asynchronous external memory pin block
// Assumes: 200 MHz core clock, synchronous active-low reset
// Notes:   Included by the main design file only
`ifndef ASYNC_MEMORY_PORT_DEFINES_VH
`define ASYNC_MEMORY_PORT_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Minimum strobe length in cycles before the acknowledge is honoured
`define STROBE_CYCLES  8'h04

////////////////////////////////////////////////////////////////////////////////
// Bank field of the access address
`define BANK_MSB       23
`define BANK_LSB       22

////////////////////////////////////////////////////////////////////////////////
// Address pin sharing
`define ADDR_FLAG_LSB  8
`define ADDR_FLAG_MSB  15
`define ADDR_PWM_LSB   0
`define ADDR_PWM_MSB   3
`define ADDR_PARALLEL_INPUT_PATH_LSB  4
`define ADDR_PARALLEL_INPUT_PATH_MSB  23

////////////////////////////////////////////////////////////////////////////////
// Low flag pin modes, two bits per pin
`define FMODE_IN       2'h0
`define FMODE_OUT      2'h1
`define FMODE_ALT      2'h2
`define FMODE_SELECT   2'h3
`define FMODE_RESET    8'h00

////////////////////////////////////////////////////////////////////////////////
// Pin-sharing reset values: every address line in memory mode
`define ADDR_FLAG_EN_RESET 1'b0
`define PWM_EN_RESET       1'b0
`define DATA_FLAG_EN_RESET 1'b0
`define PARALLEL_INPUT_PATH_EN_RESET      1'b0

`endif

/* File: design/pin_sync.v */
// Purpose: Two-flop synchroniser for a vector of pin inputs
// Assumes: Each bit is an independent level
// Notes:   The first stage feeds only the second stage
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] reset_val,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  always @(posedge clk) begin
    if (!reset_n) begin
      stage1   <= reset_val;
      sync_out <= reset_val;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // pin_sync

/* File: dv/async_memory_port_props.sv */
// Purpose: Pin checker for the async memory port
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into every async_memory_port instance
module async_memory_port_props #(
  parameter [7:0] STROBE_CYCLES = 8'h04
) (
  input wire        clk,
  input wire        reset_n,
  input wire        req_valid,
  input wire        req_ready,
  input wire        req_write,
  input wire        req_cond,
  input wire [23:0] req_addr,
  input wire        external_port_boot,
  input wire        rsp_valid,
  input wire [23:0] addr_out,
  input wire [23:0] addr_oe,
  input wire [15:0] data_oe,
  input wire [3:0]  flag_oe,
  input wire        ext_access_ack,
  input wire [1:0]  bank_select_n,
  input wire        ext_read_strobe_n,
  input wire        ext_write_strobe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] stb_cnt;
  wire        stb = !ext_read_strobe_n || !ext_write_strobe_n;
  wire        sel = bank_select_n != 2'b11;
  // Length of the current strobe in cycles
  always @(posedge clk) begin
    if (!reset_n || !stb) stb_cnt <= 8'h00;
    else stb_cnt <= stb_cnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_ext; s_take ##0 req_cond; endsequence
  AST_NO_COND: assert property (s_take ##0 !req_cond |=> rsp_valid && !sel)
    else $error("skipped access touched the pins");
  AST_SEL_ADDR: assert property (s_ext ##0 !req_addr[23] ##2 1 |->
    addr_out == $past(req_addr, 2) && bank_select_n ==
    (($past(external_port_boot, 2) || $past(req_addr[22], 2)) ? 2'b01 : 2'b10))
    else $error("address or bank select wrong");
  AST_RD_STB: assert property (s_ext ##0 !req_write |-> ##3 !ext_read_strobe_n)
    else $error("read strobe missing");
  AST_WR_STB: assert property (s_ext ##0 req_write |-> ##3 !ext_write_strobe_n)
    else $error("write strobe missing");
  AST_IDLE_SEL: assert property (req_ready [*2] |-> !sel)
    else $error("bank select active while idle");
  AST_STB_SEL: assert property (stb |-> sel ##1 sel)
    else $error("strobe outside bank select");
  AST_STB_EXCL: assert property (!(!ext_read_strobe_n && !ext_write_strobe_n))
    else $error("both strobes active");
  AST_STB_LEN: assert property ($fell(stb) |-> stb_cnt >= STROBE_CYCLES)
    else $error("strobe too short");
  AST_ACK_DONE: assert property (rsp_valid && $past(sel) |-> $past(ext_access_ack, 4))
    else $error("access ended while acknowledge low");
  AST_ACK_SYNC: assert property ($rose(ext_access_ack) && sel |-> !rsp_valid [*3])
    else $error("acknowledge used without synchronising");
  AST_RESET: assert property (disable iff (1'b0) !reset_n |=> addr_oe == 24'hffffff
    && data_oe == 16'h0000 && flag_oe == 4'h0 && bank_select_n == 2'b11)
    else $error("pin state wrong after reset");
endmodule // async_memory_port_props

bind async_memory_port async_memory_port_props #(
  .STROBE_CYCLES(STROBE_CYCLES)) u_props (.*);

/* File: dv/ext_mem_model.sv */
// Purpose: External asynchronous memory on two banks
// Assumes: Pins from async_memory_port, data pins pulled up
// Notes:   Acknowledge is held low for wait_cycles of each select
module ext_mem_model (
  input  wire        clk,
  input  wire [7:0]  wait_cycles,
  input  wire [23:0] addr_out,
  input  wire [15:0] data_out,
  input  wire [15:0] data_oe,
  input  wire [1:0]  bank_select_n,
  input  wire        ext_read_strobe_n,
  input  wire        ext_write_strobe_n,
  output wire [15:0] data_in,
  output wire        ext_access_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:511];
  logic [7:0]  cnt = 8'h00;
  wire         sel = bank_select_n != 2'b11;
  wire [8:0]   idx = {bank_select_n[0], addr_out[7:0]};
  wire [15:0]  drv = (sel && !ext_read_strobe_n) ? mem[idx] : 16'hffff;
  // Pull-up on the acknowledge when not selected
  assign ext_access_ack = !sel || cnt >= wait_cycles;
  assign data_in = (data_oe & data_out) | (~data_oe & drv);
  always @(posedge clk) begin
    cnt <= sel ? cnt + 8'h01 : 8'h00;
    if (sel && !ext_write_strobe_n) mem[idx] <= data_out;
  end
endmodule // ext_mem_model

/* File: dv/async_memory_port_bench.sv */
// Purpose: Self-checking bench for the async memory port
// Assumes: 200 MHz clock, memory model on the pins
// Notes:   Inputs change 1 ns after the rising edge
module async_memory_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, reset_n = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0, req_cond = 1'b0;
  logic [23:0] req_addr = 24'h000000, addr_in = 24'h000000;
  logic [15:0] req_wdata = 16'h0000, gpio_out = 16'h0000;
  logic [15:0] gpio_out_en = 16'h0000;
  logic        cfg_load = 1'b0, cfg_addr_flag_en = 1'b0, cfg_pwm_en = 1'b0;
  logic        cfg_data_flag_en = 1'b0, cfg_parallel_input_path_en = 1'b0;
  logic [7:0]  cfg_flag_mode = 8'h00, wait_cycles = 8'h00;
  logic        external_port_boot = 1'b0, timer_expired_out = 1'b0;
  logic [3:0]  low_flag_out = 4'h0, pwm_out = 4'h0, flag_in = 4'hf;
  wire         req_ready, rsp_valid, ext_access_ack;
  wire         ext_read_strobe_n, ext_write_strobe_n;
  wire  [15:0] rsp_rdata, gpio_in, data_out, data_oe, data_in;
  wire  [3:0]  low_flag_in, flag_out, flag_oe;
  wire  [1:0]  irq_req, bank_select_n;
  wire  [19:0] parallel_input_path;
  wire  [23:0] addr_out, addr_oe;
  int          err_count = 0, compares = 0;
  logic [23:0] n;
  logic [1:0]  s;

  async_memory_port u_async_memory_port (.*);
  ext_mem_model u_ext_mem_model (.*);

  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One access; n counts cycles to the response, s collects selects seen
  task automatic acc(input logic wr, input logic cd,
                     input logic [23:0] a, input logic [15:0] wd);
    // Idle cycle first, so every access gets its own select
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_cond = cd;
    req_addr = a;
    req_wdata = wd;
    s = 2'b00;
    n = 24'h000000;
    do begin
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      n = n + 24'h000001;
      s = s | ~bank_select_n;
    end while (rsp_valid !== 1'b1 && n < 24'h0000c8);
  endtask

  task conclude;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    chk(addr_oe, 24'hffffff);
    chk({data_oe, flag_oe, bank_select_n, ext_read_strobe_n,
         ext_write_strobe_n}, 24'h00000f);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 1'b1, {1'b0, i[0], 22'h3c}, 16'ha5c3 ^ 16'(i));
      chk(n, 24'h7);
      chk(24'(s), (i != 0) ? 24'h2 : 24'h1);
      acc(1'b0, 1'b1, {1'b0, i[0], 22'h3c}, 16'h0000);
      chk(n, 24'h7);
      chk(24'(rsp_rdata), 24'(16'ha5c3 ^ 16'(i)));
    end
    $display("bank test done");
    acc(1'b0, 1'b0, 24'h40003c, 16'h0000);
    chk({s, n[21:0]}, 24'h1);
    external_port_boot = 1'b1;
    acc(1'b0, 1'b1, 24'h00003c, 16'h0000);
    chk({s, rsp_rdata}, 24'h2a5c2);
    external_port_boot = 1'b0;
    wait_cycles = 8'h0a;
    acc(1'b0, 1'b1, 24'h00003c, 16'h0000);
    chk(n, 24'h10);
    chk(24'(rsp_rdata), 24'ha5c3);
    wait_cycles = 8'h00;
    $display("condition boot wait test done");
    cfg_parallel_input_path_en = 1'b1;
    cfg_pwm_en = 1'b1;
    cfg_data_flag_en = 1'b1;
    cfg_flag_mode = 8'h82;
    gpio_out = 16'h005a;
    gpio_out_en = 16'h00ff;
    pwm_out = 4'h9;
    timer_expired_out = 1'b1;
    flag_in = 4'he;
    addr_in = 24'habcde0;
    cfg_load = 1'b1;
    @(posedge clk);
    #1 cfg_load = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({parallel_input_path, addr_oe[23:20]}, 24'habcde0);
    chk({addr_oe[19:0], addr_out[3:0]}, 24'h0000f9);
    chk({data_out[7:0], data_oe[7:0], gpio_in[7:0]}, 24'h5aff5a);
    chk({flag_out[3], flag_oe[3], irq_req[0]}, 24'h7);
    $display("pin sharing test done");
    cfg_parallel_input_path_en = 1'b0;
    cfg_pwm_en = 1'b0;
    cfg_data_flag_en = 1'b0;
    cfg_addr_flag_en = 1'b1;
    cfg_flag_mode = 8'h79;
    gpio_out = 16'hc35a;
    gpio_out_en = 16'h0fff;
    low_flag_out = 4'h5;
    flag_in = 4'h9;
    cfg_load = 1'b1;
    @(posedge clk);
    #1 cfg_load = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({addr_out[15:8], addr_oe[15:8], gpio_in[15:8]}, 24'hc30fcd);
    chk(24'({flag_out, flag_oe, low_flag_in, irq_req, req_ready}), 24'h002ecd);
    chk({8'h00, data_oe}, 24'h000000);
    $display("flag mode test done");
    conclude;
  end

  initial begin
    #5000;
    err_count++;
    conclude;
  end
endmodule // async_memory_port_bench
